// file: design/dcfg_pkg.sv
// constants for the peripheral enable, pin select and lock block
package dcfg_pkg;
    // byte addresses on the configuration bus
    localparam logic [31:0] DCFG_PERIPH_SEL_ADDR = 32'h01b3f000;
    localparam logic [31:0] DCFG_LOCK_ADDR       = 32'h01b3f018;
    // unlock key, all 32 bits compared
    localparam logic [31:0] DCFG_UNLOCK_KEY      = 32'h10c0010c;
    // field positions in peripheral_enable_select
    localparam int DCFG_AUDIO_SEL_BIT   = 0;
    localparam int DCFG_SERIAL0_SEL_BIT = 1;
    localparam int DCFG_SERIAL1_SEL_BIT = 2;
    localparam int DCFG_TWO_WIRE_BIT    = 3;
    localparam int DCFG_VIDEO0_BIT      = 4;
    localparam int DCFG_VIDEO1_BIT      = 5;
    // implemented width of peripheral_enable_select
    localparam int DCFG_SEL_W = 6;
    // values after reset
    localparam logic [5:0] DCFG_SEL_RESET  = 6'h06;
    localparam logic       DCFG_LOCK_RESET = 1'h1;
    // cycles software waits after enabling before it touches a port
    localparam int DCFG_ENABLE_WAIT = 128;
endpackage

// file: design/dcfg_pin_route.sv
// registered ownership decode for the shared video, serial and audio pins
`timescale 1ns/1ps
`default_nettype none
module dcfg_pin_route
    import dcfg_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // configuration bits from the register
    input  wire logic video0_on_in,
    input  wire logic video1_on_in,
    input  wire logic two_wire_in,
    input  wire logic serial0_pin_select,
    input  wire logic serial1_pin_select,
    input  wire logic audio_pin_select,
    // registered enables and pin ownership
    output logic      video0_on,
    output logic      video1_on,
    output logic      two_wire_port_on,
    output logic      serial0_on,
    output logic      serial1_on,
    output logic      audio_on,
    output logic      video0_low_pins,
    output logic      video1_low_pins,
    output logic      video_upper_pins
);
    // all state of the decode
    typedef struct packed {
        logic v0;     // video port 0 powered
        logic v1;     // video port 1 powered
        logic tw;     // two-wire port powered
        logic s0;     // serial port 0 owns its pins
        logic s1;     // serial port 1 owns its pins
        logic au;     // audio port owns upper pins
        logic v0_lo;  // video 0 lower pins live
        logic v1_lo;  // video 1 lower pins live
        logic v_up;   // video upper pins live
    } dcfg_route_s;

    dcfg_route_s q;  // registered state
    dcfg_route_s d;  // next state

    // one cycle of delay keeps every pin-select output glitch free
    always_comb begin
        d.v0    = video0_on_in;       // [R1]
        d.v1    = video1_on_in;       // [R19]
        d.tw    = two_wire_in;        // [R2]
        d.s0    = serial0_pin_select; // [R4]
        d.s1    = serial1_pin_select; // [R3] [R9]
        d.au    = audio_pin_select;   // [R5]
        // lower pins ignore the audio select on purpose
        d.v0_lo = video0_on_in & ~serial0_pin_select; // [R4] [R6]
        d.v1_lo = video1_on_in & ~serial1_pin_select; // [R3] [R6]
        // upper pins of both ports go to audio as one group
        d.v_up  = ~audio_pin_select; // [R7] [R8]
    end

    // register the decode; defaults match register reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{v0:    DCFG_SEL_RESET[DCFG_VIDEO0_BIT],
                   v1:    DCFG_SEL_RESET[DCFG_VIDEO1_BIT],
                   tw:    DCFG_SEL_RESET[DCFG_TWO_WIRE_BIT],
                   s0:    DCFG_SEL_RESET[DCFG_SERIAL0_SEL_BIT],
                   s1:    DCFG_SEL_RESET[DCFG_SERIAL1_SEL_BIT],
                   au:    DCFG_SEL_RESET[DCFG_AUDIO_SEL_BIT],
                   v0_lo: DCFG_SEL_RESET[DCFG_VIDEO0_BIT] & ~DCFG_SEL_RESET[DCFG_SERIAL0_SEL_BIT],
                   v1_lo: DCFG_SEL_RESET[DCFG_VIDEO1_BIT] & ~DCFG_SEL_RESET[DCFG_SERIAL1_SEL_BIT],
                   v_up:  ~DCFG_SEL_RESET[DCFG_AUDIO_SEL_BIT]};
        end else begin
            q <= d;
        end
    end

    assign video0_on        = q.v0;
    assign video1_on        = q.v1;
    assign two_wire_port_on = q.tw;
    assign serial0_on       = q.s0;
    assign serial1_on       = q.s1;
    assign audio_on         = q.au;
    assign video0_low_pins  = q.v0_lo;
    assign video1_low_pins  = q.v1_lo;
    assign video_upper_pins = q.v_up;

    // lower pins of port 0 follow only its own bits
    a_low0_owner: assert property (@(posedge clock) disable iff (!rst_n)  // [R6]
        ##1 video0_low_pins == ($past(video0_on_in) && !$past(serial0_pin_select)))
        else $error("video 0 lower pin owner wrong");
    // lower pins of port 1 follow only its own bits
    a_low1_owner: assert property (@(posedge clock) disable iff (!rst_n)  // [R3] [R6]
        ##1 video1_low_pins == ($past(video1_on_in) && !$past(serial1_pin_select)))
        else $error("video 1 lower pin owner wrong");
    // upper pins and audio follow the select and are never both live
    a_upper_exclusive: assert property (@(posedge clock) disable iff (!rst_n)  // [R5] [R7] [R8]
        audio_on == $past(audio_pin_select) && video_upper_pins == !$past(audio_pin_select))
        else $error("audio and video upper pins overlap");
endmodule
`default_nettype wire

// file: design/dcfg_top.sv
// peripheral enable, shared pin select and key-protected lock registers
`timescale 1ns/1ps
`default_nettype none
// Rules for this block and the software that drives it
// [R1] bit 4 powers video port 0
// [R2] bit 3 powers two-wire port
// [R3] bit 2 gives pins to serial port 1
// [R4] bit 1 gives pins to serial port 0
// [R5] bit 0 gives upper pins to audio
// [R6] lower pins ignore the audio select
// [R7] video 1 upper pins carry audio data
// [R8] video 0 upper pins carry audio clocks
// [R9] video 1 pins 2-8 carry serial port 1
// [R10] software enables each port before use
// [R11] software avoids runtime pin function changes
// [R12] full key write unlocks the register
// [R13] lock read shows state, resets locked
// [R14] locked writes to config are ignored
// [R15] config reads ignore the lock
// [R16] lock upper bits read zero
// [R17] any config write relocks
// [R18] software waits 128 cycles after enable
// [R19] bit 5 powers video port 1
// [R20] only exact key match unlocks
module dcfg_top
    import dcfg_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // configuration bus from the cpu
    input  wire logic        cfg_req,
    input  wire logic        cfg_we,
    input  wire logic [31:0] cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_ack,
    // lock state seen by the rest of the chip
    output logic             lock_state_flag,
    // peripheral power enables and serial and audio pin selects
    output logic             video0_on,
    output logic             video1_on,
    output logic             two_wire_port_on,
    output logic             serial0_on,
    output logic             serial1_on,
    output logic             audio_on,
    // shared pin ownership
    output logic             video0_low_pins,
    output logic             video1_low_pins,
    output logic             video_upper_pins
);
    // all register state of the block
    typedef struct packed {
        logic [DCFG_SEL_W-1:0] sel;    // peripheral_enable_select contents
        logic                  locked; // lock state
        logic                  ack;    // bus answer strobe
        logic [31:0]           rdata;  // bus read data
    } dcfg_state_s;

    dcfg_state_s q;  // registered state
    dcfg_state_s d;  // next state

    // decoded bus cycle
    logic hit_sel;   // addresses the config register
    logic hit_lock;  // addresses the lock register
    logic wr_sel;    // write to config register
    logic wr_lock;   // write to lock register

    // full 32-bit address compare: the rest of the block reads zero
    // instead of aliasing, so a stray pointer cannot hit the lock by accident
    assign hit_sel  = (cfg_addr == DCFG_PERIPH_SEL_ADDR);
    assign hit_lock = (cfg_addr == DCFG_LOCK_ADDR);
    assign wr_sel   = cfg_req & cfg_we & hit_sel;
    assign wr_lock  = cfg_req & cfg_we & hit_lock;

    // next state: bus decode, lock handling, read mux
    always_comb begin
        d       = q;
        d.ack   = cfg_req;      // every request answered next cycle
        d.rdata = 32'h00000000; // unmapped and writes read zero
        if (wr_lock) begin
            // anything but the exact key leaves it locked
            d.locked = (cfg_wdata != DCFG_UNLOCK_KEY); // [R12] [R20] [R16]
        end
        // relock is unconditional: a dropped write still closes the lock,
        // so a stray write can never leave the register open
        if (wr_sel) begin
            if (!q.locked) begin
                // upper bits are reserved and dropped
                d.sel = cfg_wdata[DCFG_SEL_W-1:0]; // [R14]
            end
            d.locked = 1'b1; // [R17]
        end
        if (cfg_req && !cfg_we) begin
            if (hit_sel) begin
                // read is the same whether locked or not
                d.rdata = {{(32-DCFG_SEL_W){1'b0}}, q.sel}; // [R15]
            end else if (hit_lock) begin
                d.rdata = {31'h00000000, q.locked}; // [R13] [R16]
            end
        end
    end

    // single register stage for all state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{sel: DCFG_SEL_RESET, locked: DCFG_LOCK_RESET,
                   ack: 1'b0, rdata: 32'h00000000}; // [R13]
        end else begin
            q <= d;
        end
    end

    assign cfg_ack         = q.ack;
    assign cfg_rdata       = q.rdata;
    assign lock_state_flag = q.locked;

    // pin ownership decode; adds one cycle after a register change,
    // well inside the wait software keeps before touching a port
    dcfg_pin_route u_route (
        .clock              (clock),
        .rst_n              (rst_n),
        .video0_on_in       (q.sel[DCFG_VIDEO0_BIT]),
        .video1_on_in       (q.sel[DCFG_VIDEO1_BIT]),
        .two_wire_in        (q.sel[DCFG_TWO_WIRE_BIT]),
        .serial0_pin_select (q.sel[DCFG_SERIAL0_SEL_BIT]),
        .serial1_pin_select (q.sel[DCFG_SERIAL1_SEL_BIT]),
        .audio_pin_select   (q.sel[DCFG_AUDIO_SEL_BIT]),
        .video0_on          (video0_on),
        .video1_on          (video1_on),
        .two_wire_port_on   (two_wire_port_on),
        .serial0_on         (serial0_on),
        .serial1_on         (serial1_on),
        .audio_on           (audio_on),
        .video0_low_pins    (video0_low_pins),
        .video1_low_pins    (video1_low_pins),
        .video_upper_pins   (video_upper_pins)
    );

    // lock behaviour

    // exact key unlocks on the next edge
    a_key_unlock: assert property (@(posedge clock) disable iff (!rst_n)  // [R12]
        (wr_lock && cfg_wdata == DCFG_UNLOCK_KEY && !wr_sel) |=> !lock_state_flag)
        else $error("key write did not unlock");
    // wrong key leaves the lock engaged
    a_bad_key: assert property (@(posedge clock) disable iff (!rst_n)  // [R20]
        (wr_lock && cfg_wdata != DCFG_UNLOCK_KEY) |=> lock_state_flag)
        else $error("wrong key unlocked");
    // config write always relocks
    a_write_relock: assert property (@(posedge clock) disable iff (!rst_n)  // [R17]
        wr_sel |=> lock_state_flag)
        else $error("config write left it unlocked");
    // reads never disturb the lock
    a_read_quiet: assert property (@(posedge clock) disable iff (!rst_n)  // [R13]
        (cfg_req && !cfg_we) |=> $stable(lock_state_flag))
        else $error("read changed the lock");

    // enables and pin ownership after a write

    // locked write changes no enable, seen at the enables two edges on
    a_locked_ignore: assert property (@(posedge clock) disable iff (!rst_n)  // [R14]
        (wr_sel && lock_state_flag) |=> ##1
        ($stable(video0_on) && $stable(video1_on) && $stable(two_wire_port_on) &&
         $stable(serial0_on) && $stable(serial1_on) && $stable(audio_on)))
        else $error("locked write changed config");
    // unlocked write lands in the video 1 and two-wire enables two edges on
    a_unlocked_take: assert property (@(posedge clock) disable iff (!rst_n)  // [R19] [R2]
        (wr_sel && !lock_state_flag) |=> ##1
        (video1_on == $past(cfg_wdata[DCFG_VIDEO1_BIT], 2) &&
         two_wire_port_on == $past(cfg_wdata[DCFG_TWO_WIRE_BIT], 2)))
        else $error("unlocked write not applied");
    // video 0 power and its lower pins follow the write
    a_video0_take: assert property (@(posedge clock) disable iff (!rst_n)  // [R1] [R4]
        (wr_sel && !lock_state_flag) |=> ##1
        (video0_on == $past(cfg_wdata[DCFG_VIDEO0_BIT], 2) &&
         serial0_on == $past(cfg_wdata[DCFG_SERIAL0_SEL_BIT], 2) &&
         video0_low_pins == ($past(cfg_wdata[DCFG_VIDEO0_BIT], 2) &&
                             !$past(cfg_wdata[DCFG_SERIAL0_SEL_BIT], 2))))
        else $error("video 0 write not applied");
    // serial port 1 against the video 1 lower pins
    a_serial1_take: assert property (@(posedge clock) disable iff (!rst_n)  // [R3] [R9]
        (wr_sel && !lock_state_flag) |=> ##1
        (serial1_on == $past(cfg_wdata[DCFG_SERIAL1_SEL_BIT], 2) &&
         video1_low_pins == ($past(cfg_wdata[DCFG_VIDEO1_BIT], 2) &&
                             !$past(cfg_wdata[DCFG_SERIAL1_SEL_BIT], 2))))
        else $error("serial 1 write not applied");
    // audio select moves both upper groups as one
    a_audio_take: assert property (@(posedge clock) disable iff (!rst_n)  // [R5] [R7] [R8]
        (wr_sel && !lock_state_flag) |=> ##1
        (audio_on == $past(cfg_wdata[DCFG_AUDIO_SEL_BIT], 2) &&
         video_upper_pins == !$past(cfg_wdata[DCFG_AUDIO_SEL_BIT], 2)))
        else $error("audio write not applied");

    // bus answers

    // config read answers next cycle with contents, locked or not
    a_cfg_read: assert property (@(posedge clock) disable iff (!rst_n)  // [R15]
        (cfg_req && !cfg_we && hit_sel) |=>
        cfg_ack && cfg_rdata[31:DCFG_SEL_W] == '0 && cfg_rdata[DCFG_SEL_W-1:0] == $past(q.sel))
        else $error("config read wrong");
    // lock read returns state in bit 0 and zeros above
    a_lock_read: assert property (@(posedge clock) disable iff (!rst_n)  // [R13] [R16]
        (cfg_req && !cfg_we && hit_lock) |=>
        cfg_ack && cfg_rdata == {31'h00000000, $past(lock_state_flag)})
        else $error("lock read wrong");
    // writes to other addresses touch neither register
    a_unmapped_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        (cfg_req && cfg_we && !hit_sel && !hit_lock) |=>
        ($stable(lock_state_flag) && $stable(q.sel)))
        else $error("stray write changed a register");
    // every request answered exactly one cycle later
    a_ack_timing: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_ack == $past(cfg_req))
        else $error("answer strobe out of step");
    // read data is zero outside the cycle after a read
    a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !(cfg_req && !cfg_we) |=> cfg_rdata == 32'h00000000)
        else $error("read data left standing");
    // config holds still without a write
    a_sel_hold: assert property (@(posedge clock) disable iff (!rst_n)  // [R14]
        !wr_sel |=> $stable(q.sel))
        else $error("config changed without write");
endmodule
`default_nettype wire

// file: verification/tb_dcfg_top.sv
// self-checking bench for the peripheral enable, pin select and lock block
`timescale 1ns/1ps
`default_nettype none
module tb_dcfg_top;
    import dcfg_pkg::*;
    // clock and reset
    logic        clock;
    logic        rst_n;
    // configuration bus
    logic        cfg_req;
    logic        cfg_we;
    logic [31:0] cfg_addr;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic        cfg_ack;
    // lock, enables and pin ownership
    logic        lock_state_flag;
    logic        video0_on;
    logic        video1_on;
    logic        two_wire_port_on;
    logic        serial0_on;
    logic        serial1_on;
    logic        audio_on;
    logic        video0_low_pins;
    logic        video1_low_pins;
    logic        video_upper_pins;
    // bench state
    logic [31:0] pins;
    logic [31:0] junk;
    logic [5:0]  prev;
    int          err_count;
    int          checks_done;
    // config values: every select and enable both ways, audio swept against the video 1 lower pins
    logic [5:0]  vals [6] = '{6'h31, 6'h06, 6'h3f, 6'h00, 6'h15, 6'h2a};
    // keys that miss by one bit, by two bytes or in every byte
    logic [31:0] bad  [4] = '{32'h10c0010d, 32'h00c0010c, 32'hffffffff, 32'h0000010c};

    // all pin and enable outputs in one word
    assign pins = {23'h0, video1_on, video0_on, two_wire_port_on, serial0_on, serial1_on,
                   audio_on, video0_low_pins, video1_low_pins, video_upper_pins};

    dcfg_top i_dut (
        .clock            (clock),
        .rst_n            (rst_n),
        .cfg_req          (cfg_req),
        .cfg_we           (cfg_we),
        .cfg_addr         (cfg_addr),
        .cfg_wdata        (cfg_wdata),
        .cfg_rdata        (cfg_rdata),
        .cfg_ack          (cfg_ack),
        .lock_state_flag  (lock_state_flag),
        .video0_on        (video0_on),
        .video1_on        (video1_on),
        .two_wire_port_on (two_wire_port_on),
        .serial0_on       (serial0_on),
        .serial1_on       (serial1_on),
        .audio_on         (audio_on),
        .video0_low_pins  (video0_low_pins),
        .video1_low_pins  (video1_low_pins),
        .video_upper_pins (video_upper_pins)
    );

    // verdict and stop, shared by main sequence and watchdog
    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one comparison, four-state exact
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // one bus access; request is a single-cycle pulse, answer fixed one cycle later
    task automatic access(input logic we, input logic [31:0] addr, input logic [31:0] wd,
                          output logic [31:0] rd);
        @(posedge clock);
        #1;
        cfg_req   = 1'b1;
        cfg_we    = we;
        cfg_addr  = addr;
        cfg_wdata = wd;
        @(posedge clock);
        #1;
        cfg_req = 1'b0;
        chk({31'h0, cfg_ack}, 32'h1);
        rd = cfg_rdata;
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
        access(1'b1, addr, wd, junk);
    endtask

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] r;
        access(1'b0, addr, 32'h0, r);
        chk(r, exp);
    endtask

    // expected outputs from a config value; lower pins never look at the audio bit
    function automatic logic [31:0] pins_exp(input logic [5:0] c);
        return {23'h0, c[5], c[4], c[3], c[1], c[2], c[0], c[4] & ~c[1], c[5] & ~c[2], ~c[0]};
    endfunction

    // outputs settle one edge after the write edge; checked two edges after it
    task automatic check_pins(input logic [5:0] c);
        repeat (2) @(posedge clock);
        #1;
        chk(pins, pins_exp(c));
    endtask

    // free-running clock, 5 ns period
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // hang guard, far beyond the thousand or so cycles the tests need
    initial begin
        #40000;
        err_count++;
        end_of_test();
    end

    // main sequence
    initial begin
        rst_n       = 1'b0;
        cfg_req     = 1'b0;
        cfg_we      = 1'b0;
        cfg_addr    = 32'h0;
        cfg_wdata   = 32'h0;
        err_count   = 0;
        checks_done = 0;
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk(pins, pins_exp(6'h06));
        rd_chk(DCFG_LOCK_ADDR, 32'h1);
        rd_chk(DCFG_PERIPH_SEL_ADDR, 32'h06);
        // locked write must leave contents and outputs alone
        wr(DCFG_PERIPH_SEL_ADDR, 32'h3f);
        rd_chk(DCFG_PERIPH_SEL_ADDR, 32'h06);
        check_pins(6'h06);
        // wrong keys keep the lock; upper lock bits stay zero
        foreach (bad[k]) begin
            wr(DCFG_LOCK_ADDR, bad[k]);
            rd_chk(DCFG_LOCK_ADDR, 32'h1);
        end
        // right key at an unmapped address does nothing
        wr(32'h01b3f01c, DCFG_UNLOCK_KEY);
        rd_chk(32'h01b3f004, 32'h0);
        chk({31'h0, lock_state_flag}, 32'h1);
        prev = 6'h06;
        // unlock, write, relock, then a back-to-back locked write is dropped
        foreach (vals[i]) begin
            wr(DCFG_LOCK_ADDR, DCFG_UNLOCK_KEY);
            chk({31'h0, lock_state_flag}, 32'h0);
            rd_chk(DCFG_LOCK_ADDR, 32'h0);
            rd_chk(DCFG_PERIPH_SEL_ADDR, {26'h0, prev});
            // ports are only ever switched on through the unlocked register
            wr(DCFG_PERIPH_SEL_ADDR, {26'h3ffffff, vals[i]});
            chk({31'h0, lock_state_flag}, 32'h1);
            wr(DCFG_PERIPH_SEL_ADDR, {26'h0, ~vals[i]});
            rd_chk(DCFG_PERIPH_SEL_ADDR, {26'h0, vals[i]});
            // read back first, then the settling wait before a port is used
            repeat (DCFG_ENABLE_WAIT) @(posedge clock);
            check_pins(vals[i]);
            prev = vals[i];
        end
        // wrong key after unlocking engages the lock again
        wr(DCFG_LOCK_ADDR, DCFG_UNLOCK_KEY);
        wr(DCFG_LOCK_ADDR, 32'h0);
        rd_chk(DCFG_LOCK_ADDR, 32'h1);
        // second reset in mid-run restores defaults
        wr(DCFG_LOCK_ADDR, DCFG_UNLOCK_KEY);
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk(pins, pins_exp(6'h06));
        rd_chk(DCFG_LOCK_ADDR, 32'h1);
        rd_chk(DCFG_PERIPH_SEL_ADDR, 32'h06);
        end_of_test();
    end
endmodule
`default_nettype wire
